// File: inc/hpc_pkg.sv
// Package: register map, field layout and reset values of the host port configuration bank
// Contract
// - Reserved upper bits read as zero here; software writes only zeros there.
// - Bit 4 clear means host gives word addresses, set means byte addresses.
// - With separate mode off, bit 3 picks 16-bit or 32-bit multiplexed data.
// - Bit 2 clear is multiplexed address/data; set is separate address, 32-bit data.
// - Separate mode stops the memory interface driving the shared upper data pins.
// - Multiplexed page mode: host gives low 16 bits, page bytes give the rest.
// - Bit 0 enables the port; all fields reset to zero, port disabled.
// - In separate or page mode, the top page byte supplies address bits 31:24.
// - In those modes, the second page byte supplies address bits 23:16.
// - Separate mode reaches one 64K-byte page chosen only by the page bytes.
package hpc_pkg;
    localparam logic [31:0] HPC_OFS_CONFIG = 32'h40000008;
    localparam logic [31:0] HPC_OFS_TOP_BYTE = 32'h4000000C;
    localparam logic [31:0] HPC_OFS_SECOND_BYTE = 32'h40000010;
    localparam int HPC_BIT_ENABLE = 0;
    localparam int HPC_BIT_PAGE = 1;
    localparam int HPC_BIT_SEPARATE = 2;
    localparam int HPC_BIT_FULL = 3;
    localparam int HPC_BIT_BYTE_ADDR = 4;
    localparam int HPC_CFG_WIDTH = 5;
    localparam int HPC_PAGE_WIDTH = 8;
    localparam logic [4:0] HPC_CFG_RESET = 5'h00;
    localparam logic [7:0] HPC_PAGE_RESET = 8'h00;
    localparam int HPC_HOST_LOW_WIDTH = 16;
    localparam int HPC_DATA_HALF = 16;
    localparam int HPC_DATA_FULL = 32;
endpackage : hpc_pkg

// File: hw/hpc_addr_former.sv
// Address former: builds the internal address used for host accesses
`timescale 1ns/100ps
module hpc_addr_former (
    input wire logic separate_address_mode,
    input wire logic page_mode_sel,
    input wire logic byte_addressing_sel,
    input wire logic [7:0] page_top_byte,
    input wire logic [7:0] page_second_byte,
    input wire logic [31:0] host_address_pointer,
    output logic [31:0] eff_addr,
    output logic override_active
);
    // Page override applies in separate mode, or in multiplexed mode with paging
    assign override_active = separate_address_mode | page_mode_sel;

    // Word addresses are scaled to bytes; byte addresses pass unchanged
    logic [31:0] host_byte_addr;
    assign host_byte_addr = byte_addressing_sel ? host_address_pointer
                                                : {host_address_pointer[29:0], 2'b00};

    // Override keeps only the host's low 16 bits under the chosen page
    assign eff_addr = override_active ? {page_top_byte, page_second_byte, host_byte_addr[15:0]}
                                      : host_byte_addr;
endmodule : hpc_addr_former

// File: hw/hpc_config_regs.sv
// Host port configuration register bank with APB slave and address former
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
module hpc_config_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] host_address_pointer,
    output logic [31:0] host_eff_addr,
    output logic host_port_enable,
    output logic byte_addressing_sel,
    output logic separate_address_mode,
    output logic page_mode_sel,
    output logic full_width_sel,
    output logic [5:0] host_data_width,
    output logic page_override,
    output logic shared_pins_drive_allow
);
    logic [4:0] host_port_config_r;
    logic [7:0] host_page_top_byte_r;
    logic [7:0] host_page_second_byte_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [31:0] eff_addr;
    logic override_active;
    logic wr_en;
    logic rd_en;
    logic hit_cfg;
    logic hit_top;
    logic hit_second;

    // Address decode; one aligned word per register
    assign hit_cfg = (paddr == hpc_pkg::HPC_OFS_CONFIG);
    assign hit_top = (paddr == hpc_pkg::HPC_OFS_TOP_BYTE);
    assign hit_second = (paddr == hpc_pkg::HPC_OFS_SECOND_BYTE);
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    // Zero wait states keeps the CPU's configuration writes short
    assign pready = 1'b1;

    // Configuration register; all fields clear so the port starts disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_port_config_r <= hpc_pkg::HPC_CFG_RESET;
        end else if (wr_en && hit_cfg && pstrb[0]) begin
            host_port_config_r <= pwdata[4:0];
        end
    end

    // Page byte registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_page_top_byte_r <= hpc_pkg::HPC_PAGE_RESET;
            host_page_second_byte_r <= hpc_pkg::HPC_PAGE_RESET;
        end else if (wr_en && pstrb[0]) begin
            if (hit_top) begin
                host_page_top_byte_r <= pwdata[7:0];
            end
            if (hit_second) begin
                host_page_second_byte_r <= pwdata[7:0];
            end
        end
    end

    // Read data and error; reserved bits read zero, unmapped answers with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_r <= ~(hit_cfg | hit_top | hit_second);
            if (!pwrite && hit_cfg) begin
                prdata_r <= {27'h0000000, host_port_config_r};
            end else if (!pwrite && hit_top) begin
                prdata_r <= {24'h000000, host_page_top_byte_r};
            end else if (!pwrite && hit_second) begin
                prdata_r <= {24'h000000, host_page_second_byte_r};
            end else begin
                prdata_r <= 32'h00000000;
            end
        end
    end
    assign prdata = rd_en ? prdata_r : 32'h00000000;
    assign pslverr = psel & penable & pslverr_r;

    // Mode outputs decoded from the configuration fields
    assign host_port_enable = host_port_config_r[hpc_pkg::HPC_BIT_ENABLE];
    assign byte_addressing_sel = host_port_config_r[hpc_pkg::HPC_BIT_BYTE_ADDR];
    assign separate_address_mode = host_port_config_r[hpc_pkg::HPC_BIT_SEPARATE];
    assign page_mode_sel = host_port_config_r[hpc_pkg::HPC_BIT_PAGE] & ~separate_address_mode;
    assign full_width_sel = separate_address_mode | host_port_config_r[hpc_pkg::HPC_BIT_FULL];
    assign host_data_width = full_width_sel ? 6'(hpc_pkg::HPC_DATA_FULL)
                                            : 6'(hpc_pkg::HPC_DATA_HALF);
    // Shared pins become host address inputs in separate mode, enabled or not
    assign shared_pins_drive_allow = ~separate_address_mode;

    hpc_addr_former u_addr (
        .separate_address_mode(separate_address_mode),
        .page_mode_sel(page_mode_sel),
        .byte_addressing_sel(byte_addressing_sel),
        .page_top_byte(host_page_top_byte_r),
        .page_second_byte(host_page_second_byte_r),
        .host_address_pointer(host_address_pointer),
        .eff_addr(eff_addr),
        .override_active(override_active)
    );
    assign host_eff_addr = eff_addr;
    assign page_override = override_active;
endmodule : hpc_config_regs

// File: sim/hpc_host_model.sv
// Host-side model: presents the host address pointer
`timescale 1ns/100ps
module hpc_host_model (
    input wire logic pclk,
    input wire logic [31:0] ptr_in,
    output logic [31:0] host_address_pointer
);
    // Pointer set up by the host before data accesses
    always_ff @(posedge pclk) host_address_pointer <= ptr_in;
endmodule : hpc_host_model

// File: sim/hpc_config_asserts.sv
// Checker for the host port configuration bank
`timescale 1ns/100ps
module hpc_config_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] host_address_pointer,
    input wire logic [31:0] host_eff_addr,
    input wire logic host_port_enable,
    input wire logic byte_addressing_sel,
    input wire logic separate_address_mode,
    input wire logic page_mode_sel,
    input wire logic full_width_sel,
    input wire logic [5:0] host_data_width,
    input wire logic page_override,
    input wire logic shared_pins_drive_allow
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write strobe on the low lane, the only lane holding fields
    logic wr;
    logic [31:0] lo;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign lo = byte_addressing_sel ? host_address_pointer : host_address_pointer << 2;
    a_reset_off: assert property ($rose(presetn) |-> !host_port_enable && shared_pins_drive_allow)
        else $error("port not idle after reset");
    a_sep_pins: assert property (separate_address_mode |-> !shared_pins_drive_allow)
        else $error("shared pins driven in separate mode");
    a_half_width: assert property (!separate_address_mode && !full_width_sel |-> host_data_width == 6'h10)
        else $error("half width wrong");
    a_sep_width: assert property (separate_address_mode |-> host_data_width == 6'h20 && page_override)
        else $error("separate mode width wrong");
    a_page_sel: assert property (page_mode_sel |-> page_override && !separate_address_mode)
        else $error("page mode inconsistent");
    a_full_addr: assert property (!page_override |-> host_eff_addr == lo)
        else $error("full address wrong");
    a_low_bits: assert property (page_override |-> host_eff_addr[15:0] == lo[15:0])
        else $error("low address bits wrong");
    a_top_byte: assert property (wr && paddr == hpc_pkg::HPC_OFS_TOP_BYTE && page_override |=>
        host_eff_addr[31:24] == $past(pwdata[7:0])) else $error("top byte not applied");
    a_cfg_write: assert property (wr && paddr == hpc_pkg::HPC_OFS_CONFIG |=>
        host_port_enable == $past(pwdata[0])) else $error("enable not written");
    cover property (page_mode_sel);
    cover property (separate_address_mode);
    cover property (host_port_enable && full_width_sel);
endmodule : hpc_config_asserts
bind hpc_config_regs hpc_config_asserts i_chk (.*);

// File: sim/tb_top.sv
// Testbench for the host port configuration bank
`timescale 1ns/100ps
module tb_top;
    localparam logic [31:0] PTR = 32'h00012345;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, host_port_enable, byte_addressing_sel;
    logic separate_address_mode, page_mode_sel, full_width_sel, page_override, shared_pins_drive_allow;
    logic [31:0] paddr, pwdata, prdata, host_address_pointer, host_eff_addr, rd, lo;
    logic [3:0] pstrb;
    logic [5:0] host_data_width;
    int bad_count, tests_run;
    // Row: config value, then enable, byte, separate, page, full, override, drive, width
    logic [17:0] rows [4] = '{18'h03050, 18'h34BE0, 18'h1B5A0, 18'h0C5A0};
    hpc_config_regs i_dut (.*);
    hpc_host_model i_host (.pclk(pclk), .ptr_in(PTR), .host_address_pointer(host_address_pointer));
    always #2 pclk = ~pclk;
    task automatic results();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; waits a bounded time for pready
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        // Start on a fresh edge so a released strobe is never raised in the same step
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Mode outputs change at the access edge; look at them once settled
        @(negedge pclk);
        if (n == 50) begin
            bad_count++;
            results();
        end
    endtask : apb
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'h1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(hpc_pkg::HPC_OFS_CONFIG, 1'b0, 32'h0);
        chk({host_port_enable, shared_pins_drive_allow, host_data_width, rd[7:0]}, 16'h5000);
        // Boot code takes the shared pins away from the memory interface first
        apb(hpc_pkg::HPC_OFS_CONFIG, 1'b1, 32'h00000004);
        chk(shared_pins_drive_allow, 1'b0);
        foreach (rows[i]) begin
            // Mode fields first, enable last
            apb(hpc_pkg::HPC_OFS_CONFIG, 1'b1, {27'h0, rows[i][17:14], 1'b0});
            apb(hpc_pkg::HPC_OFS_CONFIG, 1'b1, {27'h0, rows[i][17:13]});
            apb(hpc_pkg::HPC_OFS_TOP_BYTE, 1'b1, 32'hA5);
            apb(hpc_pkg::HPC_OFS_SECOND_BYTE, 1'b1, 32'h3C);
            chk({host_port_enable, byte_addressing_sel, separate_address_mode, page_mode_sel, full_width_sel,
                page_override, shared_pins_drive_allow, host_data_width}, rows[i][12:0]);
            lo = rows[i][17] ? PTR : PTR << 2;
            chk(host_eff_addr, rows[i][7] ? {16'hA53C, lo[15:0]} : lo);
            apb(hpc_pkg::HPC_OFS_CONFIG, 1'b0, 32'h0);
            chk(rd, {27'h0, rows[i][17:13]});
        end
        // Unmapped address must be refused
        apb(32'h40000014, 1'b0, 32'h0);
        chk(serr, 1'b1);
        // Mid-run reset must return the port to disabled, half width, pins released
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({host_port_enable, shared_pins_drive_allow, host_data_width}, 8'h50);
        results();
    end
endmodule : tb_top
